// [include/register_read_pkg.sv]
// Constants shared by the register read responder and its register map.
package register_read_pkg;

  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam logic [7:0]  FC_HOLDING    = 8'h03;
  localparam logic [7:0]  FC_INPUT      = 8'h04;
  localparam logic [7:0]  EXC_FLAG      = 8'h80;
  localparam logic [7:0]  EXC_FUNCTION  = 8'h01;
  localparam logic [7:0]  EXC_ADDRESS   = 8'h02;
  localparam logic [7:0]  EXC_VALUE     = 8'h03;
  localparam logic [7:0]  STATION_MIN   = 8'h01;
  localparam logic [7:0]  STATION_MAX   = 8'hf7;
  localparam logic [3:0]  REQ_BYTES     = 4'hc;
  localparam logic [15:0] REQ_LENGTH    = 16'h0006;
  localparam logic [15:0] MAX_WORDS     = 16'h007d;
  localparam logic [8:0]  HDR_BYTES     = 9'h006;
  localparam logic [15:0] EXC_LENGTH    = 16'h0003;
  localparam logic [15:0] OK_LENGTH     = 16'h0003;
  localparam logic [8:0]  POS_LEN_HI    = 9'h004;
  localparam logic [8:0]  POS_LEN_LO    = 9'h005;
  localparam logic [8:0]  POS_STATION   = 9'h006;
  localparam logic [8:0]  POS_FUNCTION  = 9'h007;
  localparam logic [8:0]  POS_COUNT     = 9'h008;
  localparam logic [8:0]  POS_DATA      = 9'h009;

  // ==========================================================================
  // Register spaces
  // ==========================================================================
  localparam int          NAME_WORDS    = 4;
  localparam logic [15:0] HOLD_AO_BASE  = 16'h0000;
  localparam logic [15:0] HOLD_PRESET   = 16'h0100;
  localparam logic [15:0] HOLD_WATCHDOG = 16'h0101;
  localparam logic [15:0] HOLD_NAME     = 16'h0102;
  localparam logic [15:0] HOLD_TIMEOUT  = 16'h0106;
  localparam logic [15:0] IN_AI_BASE    = 16'h0000;
  localparam logic [15:0] IN_COUNTER    = 16'h0100;
  localparam logic [15:0] IN_DI_COUNT   = 16'h0101;
  localparam logic [15:0] IN_DO_COUNT   = 16'h0102;

  typedef enum logic [2:0]
  {
    st_collect = 3'b001,
    st_check   = 3'b010,
    st_send    = 3'b100
  } state_type;

endpackage : register_read_pkg

// [rtl/register_space_map.sv]
// Address decoder for the stored-settings and live-value register spaces.
`timescale 1ns/10ps
module register_space_map
  import register_read_pkg::*;
#(
  parameter int AO_N = 2,
  parameter int AI_N = 2
)
(
  input  wire logic                     live_space,
  input  wire logic [15:0]              addr,
  input  wire logic [15:0]              counter_preset,
  input  wire logic [15:0]              watchdog_setting,
  input  wire logic [16*NAME_WORDS-1:0] module_name,
  input  wire logic [15:0]              tcp_timeout,
  input  wire logic [16*AO_N-1:0]       ao_values,
  input  wire logic [15:0]              counter_value,
  input  wire logic [15:0]              di_channels,
  input  wire logic [15:0]              do_channels,
  input  wire logic [16*AI_N-1:0]       ai_values,
  output logic      [15:0]              word,
  output logic                          hit
);

  logic [15:0] offset;

  // ==========================================================================
  // Decode
  // ==========================================================================
  always_comb
  begin
    word   = 16'h0000;
    hit    = 1'b0;
    offset = 16'h0000;
    if (!live_space)
    begin
      if (addr - HOLD_AO_BASE < 16'(AO_N))
      begin
        offset = addr - HOLD_AO_BASE;
        word   = ao_values[16*offset +: 16];
        hit    = 1'b1;
      end
      else if (addr == HOLD_PRESET)
      begin
        word = counter_preset;
        hit  = 1'b1;
      end
      else if (addr == HOLD_WATCHDOG)
      begin
        word = watchdog_setting;
        hit  = 1'b1;
      end
      else if (addr >= HOLD_NAME && addr - HOLD_NAME < 16'(NAME_WORDS))
      begin
        // The first character sits in the top byte of the lowest word.
        offset = addr - HOLD_NAME;
        word   = module_name[16*(NAME_WORDS-1-offset) +: 16];
        hit    = 1'b1;
      end
      else if (addr == HOLD_TIMEOUT)
      begin
        word = tcp_timeout;
        hit  = 1'b1;
      end
    end
    else
    begin
      if (addr - IN_AI_BASE < 16'(AI_N))
      begin
        offset = addr - IN_AI_BASE;
        word   = ai_values[16*offset +: 16];
        hit    = 1'b1;
      end
      else if (addr == IN_COUNTER)
      begin
        word = counter_value;
        hit  = 1'b1;
      end
      else if (addr == IN_DI_COUNT)
      begin
        word = di_channels;
        hit  = 1'b1;
      end
      else if (addr == IN_DO_COUNT)
      begin
        word = do_channels;
        hit  = 1'b1;
      end
    end
  end

endmodule : register_space_map

// [rtl/register_read_responder.sv]
// Answers holding and input register read requests carried in TCP frames.
`timescale 1ns/10ps
module register_read_responder
  import register_read_pkg::*;
#(
  parameter int AO_N = 2,
  parameter int AI_N = 2
)
(
  input  wire logic                                        clock,
  input  wire logic                                        sys_rst,
  input  wire logic [7:0]                                  station_id,
  input  wire logic [7:0]                                  rx_data,
  input  wire logic                                        rx_valid,
  input  wire logic                                        rx_last,
  output logic                                             rx_ready,
  output logic      [7:0]                                  tx_data,
  output logic                                             tx_valid,
  output logic                                             tx_last,
  input  wire logic                                        tx_ready,
  input  wire logic [15:0]                                 counter_preset,
  input  wire logic [15:0]                                 watchdog_setting,
  input  wire logic [16*register_read_pkg::NAME_WORDS-1:0] module_name,
  input  wire logic [15:0]                                 tcp_timeout,
  input  wire logic [16*AO_N-1:0]                          ao_values,
  input  wire logic [15:0]                                 counter_value,
  input  wire logic [15:0]                                 di_channels,
  input  wire logic [15:0]                                 do_channels,
  input  wire logic [16*AI_N-1:0]                          ai_values
);
  import register_read_pkg::*;

  state_type   state;
  state_type   next_state;
  logic [7:0]  req [0:11];
  logic [7:0]  next_req [0:11];
  logic [3:0]  rx_count;
  logic [3:0]  next_rx_count;
  logic [8:0]  idx;
  logic [8:0]  next_idx;
  logic [6:0]  scan;
  logic [6:0]  next_scan;
  logic        exc;
  logic        next_exc;
  logic [7:0]  exc_code;
  logic [7:0]  next_exc_code;
  logic        next_rx_ready;
  logic [7:0]  next_tx_data;
  logic        next_tx_valid;
  logic        next_tx_last;

  logic [7:0]  fcode;
  logic [15:0] start;
  logic [15:0] wcount;
  logic [15:0] length;
  logic [8:0]  total;
  logic        station_ok;
  logic        live_space;
  logic [15:0] word_addr;
  logic [15:0] word;
  logic        hit;
  logic [8:0]  out_pos;

  // ==========================================================================
  // Request fields and reply length
  // ==========================================================================
  assign fcode      = req[7];
  assign start      = {req[8], req[9]};
  assign wcount     = {req[10], req[11]};
  assign live_space = (fcode == FC_INPUT);
  assign length     = exc ? EXC_LENGTH : OK_LENGTH + {wcount[14:0], 1'b0};
  assign total      = HDR_BYTES + length[8:0];
  assign out_pos    = idx - 9'h001;
  // Out-of-range station numbers never match, even if the strap is bad.
  assign station_ok = req[6] == station_id && req[6] >= STATION_MIN && req[6] <= STATION_MAX;
  // Data words are fetched in ascending order from the start address.
  assign word_addr  = (state == st_check) ? start + {9'h000, scan}
                                          : start + {8'h00, 8'((idx - POS_DATA) >> 1)};

  register_space_map #(
    .AO_N (AO_N),
    .AI_N (AI_N)
  ) map (
    .live_space       (live_space),
    .addr             (word_addr),
    .counter_preset   (counter_preset),
    .watchdog_setting (watchdog_setting),
    .module_name      (module_name),
    .tcp_timeout      (tcp_timeout),
    .ao_values        (ao_values),
    .counter_value    (counter_value),
    .di_channels      (di_channels),
    .do_channels      (do_channels),
    .ai_values        (ai_values),
    .word             (word),
    .hit              (hit)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    next_state    = state;
    next_req      = req;
    next_rx_count = rx_count;
    next_idx      = idx;
    next_scan     = scan;
    next_exc      = exc;
    next_exc_code = exc_code;
    next_tx_data  = tx_data;
    next_tx_valid = tx_valid;
    next_tx_last  = tx_last;
    case (state)
      st_collect:
      begin
        if (rx_valid && rx_ready)
        begin
          if (rx_count < REQ_BYTES)
          begin
            next_req[rx_count] = rx_data;
          end
          next_rx_count = rx_last ? 4'h0 : (rx_count == REQ_BYTES ? rx_count : rx_count + 4'h1);
          // Only a twelve-byte frame whose length field says six is a read.
          if (rx_last && rx_count == REQ_BYTES - 4'h1 && {req[4], req[5]} == REQ_LENGTH)
          begin
            next_state = st_check;
            next_scan  = 7'h00;
          end
        end
      end
      st_check:
      begin
        next_idx = 9'h000;
        next_exc = 1'b1;
        if (!station_ok)
        begin
          next_state = st_collect;
        end
        else if (fcode != FC_HOLDING && fcode != FC_INPUT)
        begin
          next_exc_code = EXC_FUNCTION;
          next_state    = st_send;
        end
        else if (wcount == 16'h0000 || wcount > MAX_WORDS)
        begin
          next_exc_code = EXC_VALUE;
          next_state    = st_send;
        end
        else if (!hit)
        begin
          // Every word of the range is probed before the reply starts.
          next_exc_code = EXC_ADDRESS;
          next_state    = st_send;
        end
        else if ({9'h000, scan} == wcount - 16'h0001)
        begin
          next_exc   = 1'b0;
          next_state = st_send;
        end
        else
        begin
          next_scan = scan + 7'h01;
        end
      end
      st_send:
      begin
        if (!tx_valid || tx_ready)
        begin
          if (idx < total)
          begin
            next_tx_valid = 1'b1;
            next_tx_last  = (idx == total - 9'h001);
            next_idx      = idx + 9'h001;
            if (idx < POS_LEN_HI)
            begin
              next_tx_data = req[idx[1:0]];
            end
            else if (idx == POS_LEN_HI)
            begin
              next_tx_data = length[15:8];
            end
            else if (idx == POS_LEN_LO)
            begin
              next_tx_data = length[7:0];
            end
            else if (idx == POS_STATION)
            begin
              next_tx_data = req[6];
            end
            else if (idx == POS_FUNCTION)
            begin
              next_tx_data = exc ? (fcode | EXC_FLAG) : fcode;
            end
            else if (idx == POS_COUNT)
            begin
              next_tx_data = exc ? exc_code : {wcount[6:0], 1'b0};
            end
            else
            begin
              // Odd positions carry the high byte of each word.
              next_tx_data = idx[0] ? word[15:8] : word[7:0];
            end
          end
          else
          begin
            next_tx_valid = 1'b0;
            next_tx_last  = 1'b0;
            next_state    = st_collect;
          end
        end
      end
      default:
      begin
        next_state = st_collect;
      end
    endcase
    // Input is held off while a request is judged or answered.
    next_rx_ready = (next_state == st_collect);
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state    <= st_collect;
      req      <= '{default: 8'h00};
      rx_count <= 4'h0;
      idx      <= 9'h000;
      scan     <= 7'h00;
      exc      <= 1'b0;
      exc_code <= 8'h00;
      rx_ready <= 1'b0;
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      req      <= next_req;
      rx_count <= next_rx_count;
      idx      <= next_idx;
      scan     <= next_scan;
      exc      <= next_exc;
      exc_code <= next_exc_code;
      rx_ready <= next_rx_ready;
      tx_data  <= next_tx_data;
      tx_valid <= next_tx_valid;
      tx_last  <= next_tx_last;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_foreign;
    state == st_check && !station_ok;
  endsequence

  sequence s_quiet;
    (state == st_collect && !tx_valid) [*2];
  endsequence

  station_echo_a: assert property (tx_valid && out_pos == POS_STATION |-> tx_data == req[6])
    else $error("reply station differs from request");

  hold_function_a: assert property (tx_valid && out_pos == POS_FUNCTION && !exc |-> tx_data == fcode
    && (fcode == FC_HOLDING || fcode == FC_INPUT))
    else $error("good reply for an unknown function");

  bad_function_a: assert property (state == st_check && station_ok && fcode != FC_HOLDING
    && fcode != FC_INPUT |=> exc && exc_code == EXC_FUNCTION)
    else $error("unknown function not refused");

  byte_count_a: assert property (tx_valid && out_pos == POS_COUNT && !exc
    |-> tx_data == 8'(2 * wcount))
    else $error("byte count is not twice the word count");

  first_word_a: assert property (tx_valid && out_pos == POS_COUNT && !exc |-> word_addr == start && hit)
    else $error("data does not start at the requested address");

  exception_reply_a: assert property (tx_valid && tx_ready && out_pos == POS_FUNCTION && exc
    |-> tx_data == (fcode | EXC_FLAG) ##1 tx_valid && tx_last && tx_data == exc_code)
    else $error("exception reply malformed");

  preset_map_a: assert property (!live_space && word_addr == HOLD_PRESET |-> hit
    && word == counter_preset)
    else $error("counter preset not mapped");

  di_map_a: assert property (live_space && word_addr == IN_DI_COUNT |-> hit && word == di_channels)
    else $error("input channel count not mapped");

  length_field_a: assert property (tx_valid && out_pos == POS_LEN_LO |-> tx_data == length[7:0]
    && length == (exc ? EXC_LENGTH : OK_LENGTH + 16'(2 * wcount)))
    else $error("length field wrong");

  last_byte_a: assert property (tx_valid && tx_last |-> out_pos == total - 9'h001)
    else $error("frame ends at the wrong byte");

  name_order_a: assert property (!live_space && word_addr == HOLD_NAME
    |-> word == module_name[16*NAME_WORDS-1 -: 16])
    else $error("first name characters not in the lowest word");

  range_a: assert property (state == st_check && station_ok && !hit
    && (fcode == FC_HOLDING || fcode == FC_INPUT) && wcount != 16'h0000 && wcount <= MAX_WORDS
    |=> state == st_send && exc && exc_code == EXC_ADDRESS)
    else $error("unmapped range not refused");

  foreign_a: assert property (s_foreign |=> s_quiet)
    else $error("reply to a foreign station");

endmodule : register_read_responder

// [verification/modbus_client_model.sv]
// Network client model that sends read request frames and gathers the reply bytes.
`timescale 1ns/10ps
module modbus_client_model
(
  input  wire logic       clock,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            rx_last,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_ready,
  input  wire logic       stall
);
  logic [7:0] reply_q[$];
  int         replies = 0;

  initial
  begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    rx_last  = 1'b0;
    tx_ready = 1'b1;
  end

  // The sink may hold back at any cycle; the responder must keep its byte until taken.
  always @(negedge clock)
    tx_ready <= !stall;

  always @(posedge clock)
  begin
    if (tx_valid && tx_ready)
    begin
      reply_q.push_back(tx_data);
      if (tx_last)
        replies = replies + 1;
    end
  end

  // ==========================================================================
  // Request frames
  // ==========================================================================
  task automatic send_request(input logic [31:0] mn, input logic [7:0] st, input logic [7:0] fc,
                              input logic [15:0] addr, input logic [15:0] cnt);
    logic [7:0] fr[12];
    int         i;
    logic       seen;
    fr = '{mn[31:24], mn[23:16], mn[15:8], mn[7:0], 8'h00, 8'h06,
           st, fc, addr[15:8], addr[7:0], cnt[15:8], cnt[7:0]};
    for (i = 0; i < 12; i++)
    begin
      @(negedge clock);
      rx_data  = fr[i];
      rx_valid = 1'b1;
      rx_last  = (i == 11);
      seen     = rx_ready;
      @(posedge clock);
      while (!seen)
      begin
        @(negedge clock);
        seen = rx_ready;
        @(posedge clock);
      end
    end
    // A released data line must not look like a held byte, so it shows the inverse.
    @(negedge clock);
    rx_valid = 1'b0;
    rx_last  = 1'b0;
    rx_data  = ~rx_data;
  endtask : send_request
endmodule : modbus_client_model

// [verification/testbench.sv]
// Self-checking bench for the register read responder against a behavioural reply model.
`timescale 1ns/10ps
module testbench;
  import register_read_pkg::*;
  localparam int AO_N = 3;
  localparam int AI_N = 2;

  logic                 clock = 1'b0;
  logic                 sys_rst = 1'b1;
  logic [7:0]           station_id = 8'h11;
  logic [7:0]           rx_data;
  logic                 rx_valid;
  logic                 rx_last;
  logic                 rx_ready;
  logic [7:0]           tx_data;
  logic                 tx_valid;
  logic                 tx_last;
  logic                 tx_ready;
  logic                 stall = 1'b0;
  logic                 slow = 1'b0;
  logic [15:0]          counter_preset, watchdog_setting, tcp_timeout;
  logic [15:0]          counter_value, di_channels, do_channels;
  logic [63:0]          module_name = "LIGHTMON";
  logic [16*AO_N-1:0]   ao_values;
  logic [16*AI_N-1:0]   ai_values;
  logic [31:0]          seed = 32'hf68c;
  logic [31:0]          stall_seed = 32'hf68c;
  int                   bad_count = 0;
  int                   checked = 0;

  always #2.5 clock = ~clock;

  register_read_responder #(.AO_N(AO_N), .AI_N(AI_N)) i_dut (
    .clock(clock), .sys_rst(sys_rst), .station_id(station_id), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .counter_preset(counter_preset),
    .watchdog_setting(watchdog_setting), .module_name(module_name), .tcp_timeout(tcp_timeout),
    .ao_values(ao_values), .counter_value(counter_value), .di_channels(di_channels),
    .do_channels(do_channels), .ai_values(ai_values));

  modbus_client_model i_client (
    .clock(clock), .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .stall(stall));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  always @(negedge clock)
  begin
    stall_seed = lfsr_next(stall_seed);
    stall      = slow & stall_seed[0];
  end

  task automatic new_values;
    seed             = lfsr_next(seed);
    counter_preset   = seed[15:0];
    watchdog_setting = seed[31:16];
    seed             = lfsr_next(seed);
    tcp_timeout      = seed[15:0];
    counter_value    = seed[31:16];
    seed             = lfsr_next(seed);
    di_channels      = seed[15:0];
    do_channels      = seed[31:16];
    ao_values        = {seed, seed[15:0] ^ 16'h5a5a};
    ai_values        = ~seed;
  endtask : new_values

  // ==========================================================================
  // Reply model
  // ==========================================================================
  function automatic bit reg_word(input bit live, input int a, output logic [15:0] w);
    w = 16'h0000;
    if (live)
    begin
      if (a < AI_N) w = ai_values[16*a +: 16];
      else if (a == IN_COUNTER) w = counter_value;
      else if (a == IN_DI_COUNT) w = di_channels;
      else if (a == IN_DO_COUNT) w = do_channels;
      else return 1'b0;
    end
    else
    begin
      if (a < AO_N) w = ao_values[16*a +: 16];
      else if (a == HOLD_PRESET) w = counter_preset;
      else if (a == HOLD_WATCHDOG) w = watchdog_setting;
      else if (a >= HOLD_NAME && a < HOLD_NAME + NAME_WORDS) w = module_name[63-16*(a-HOLD_NAME) -: 16];
      else if (a == HOLD_TIMEOUT) w = tcp_timeout;
      else return 1'b0;
    end
    return 1'b1;
  endfunction : reg_word

  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    checked++;
    if (seen !== expected)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic run_req(input logic [7:0] st, input logic [7:0] fc, input int addr, input int cnt);
    logic [31:0] mn;
    logic [7:0]  exp_q[$];
    logic [15:0] w;
    int          i, ec, n0, k;
    seed = lfsr_next(seed);
    mn   = seed;
    ec   = 0;
    if (fc != FC_HOLDING && fc != FC_INPUT) ec = 1;
    else if (cnt == 0 || cnt > 125) ec = 3;
    else for (i = 0; i < cnt; i++) if (!reg_word(fc == FC_INPUT, addr + i, w)) ec = 2;
    exp_q = {mn[31:24], mn[23:16], mn[15:8], mn[7:0], 8'h00, 8'h03, st, fc | EXC_FLAG, 8'(ec)};
    if (ec == 0)
    begin
      exp_q[5] = 8'(3 + 2 * cnt);
      exp_q[7] = fc;
      exp_q[8] = 8'(2 * cnt);
      for (i = 0; i < cnt; i++)
      begin
        void'(reg_word(fc == FC_INPUT, addr + i, w));
        exp_q.push_back(w[15:8]);
        exp_q.push_back(w[7:0]);
      end
    end
    if (st !== station_id || st < STATION_MIN || st > STATION_MAX) exp_q.delete();
    i_client.reply_q.delete();
    n0 = i_client.replies;
    i_client.send_request(mn, st, fc, addr[15:0], cnt[15:0]);
    k = 0;
    while (i_client.replies == n0 && k < 400)
    begin
      @(negedge clock);
      k++;
    end
    check(16'(i_client.reply_q.size()), 16'(exp_q.size()));
    check(16'(i_client.replies - n0), 16'(exp_q.size() != 0));
    for (i = 0; i < exp_q.size() && i < i_client.reply_q.size(); i++)
      check({8'h00, i_client.reply_q[i]}, {8'h00, exp_q[i]});
    $display("test done: station %h function %h address %h words %0d", st, fc, addr[15:0], cnt);
  endtask : run_req

  task automatic stop_test;
    $display("Counts: %0d compared, %0d mismatched", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (40000) @(posedge clock);
    bad_count++;
    stop_test();
  end

  initial
  begin
    int j;
    new_values();
    repeat (16) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    repeat (2) @(negedge clock);
    run_req(8'h11, FC_HOLDING, HOLD_NAME, NAME_WORDS);
    run_req(8'h11, FC_HOLDING, HOLD_PRESET, 7);
    run_req(8'h11, FC_HOLDING, 0, AO_N);
    run_req(8'h11, FC_INPUT, 0, AI_N);
    run_req(8'h11, FC_INPUT, IN_COUNTER, 3);
    run_req(8'h11, FC_HOLDING, HOLD_TIMEOUT, 2);
    run_req(8'h11, FC_INPUT, AI_N, 1);
    run_req(8'h11, FC_HOLDING, 0, 0);
    run_req(8'h11, FC_INPUT, 0, 126);
    run_req(8'h11, 8'h10, 0, 1);
    run_req(8'h12, FC_HOLDING, 0, 1);
    station_id = STATION_MIN;
    run_req(STATION_MIN, FC_INPUT, IN_DO_COUNT, 1);
    station_id = STATION_MAX;
    run_req(STATION_MAX, FC_HOLDING, 1, 2);
    station_id = 8'hf8;
    run_req(8'hf8, FC_HOLDING, 0, 1);
    station_id = 8'h11;
    slow = 1'b1;
    for (j = 0; j < 10; j++)
    begin
      new_values();
      run_req(8'h11, seed[9] ? FC_INPUT : FC_HOLDING, (seed[8] ? 'h100 : 0) + seed[3:2], 1 + seed[5:4]);
    end
    stop_test();
  end
endmodule : testbench
